// >>> include/pmu_pkg.sv
// package for the power-management i2c register slave
// holds addresses, register offsets, field positions and reset values
package pmu_pkg;
    localparam logic [6:0] REG_SLAVE_ADDR = 7'h48;
    localparam logic [6:0] MEM_SLAVE_ADDR = 7'h58;
    localparam logic [7:0] OFF_DEVICE_IDENTITY = 8'h00;
    localparam logic [7:0] OFF_MEMORY_PROGRAM_REVISION = 8'h01;
    localparam logic [7:0] OFF_PIN_OUTPUT_CONTROL = 8'h02;
    localparam logic [7:0] OFF_PASSWORD = 8'h0F;
    localparam logic [15:0] MEM_TOP_ADDR = 16'h0FFF;
    localparam logic [7:0] PIN_CTRL_RESET = 8'h38;
    localparam logic [7:0] PIN_CTRL_WMASK = 8'h3B;
    localparam int BIT_IO_TYPE = 5;
    localparam int BIT_IO_DIR = 4;
    localparam int BIT_IO_LEVEL = 3;
    localparam int BIT_OUT_TYPE = 1;
    localparam int BIT_OUT_LEVEL = 0;
    localparam int REV_FIELD_WIDTH = 7;
    localparam int MEM_BUSY_CYCLES = 16;
    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_TXACK, ST_SKIP
    } i2c_state_t;
endpackage : pmu_pkg

// >>> src/pmu_i2c_register_slave.sv
// i2c slave with the register bank and the user memory port of a small pmu
// assumes scl/sda already synchronous to clock_i; the memory is a plain
// byte array here, defaults for the bank arrive on otp_* inputs at lockout release
//
// Summary of operation
// - register address: address byte, one register-address byte, one data byte.
// - memory address: low address byte, high address byte, one data byte.
// - undefined register addresses read back as 00h.
// - sda changes only while scl low; high-phase changes mark start/stop.
// - device holds sda low through the ack clock high phase.
// - on master nack during a read, device releases sda high.
// - lockout or stop returns the serial state machine to idle.
// - unstable lines at lockout release may leave first transfer unacknowledged.
// - spurious start at power-up runs a sync clock until stop.
// - register 00h holds read-only part code and die revision nibbles.
// - register 01h: bit 7 zero, bits 6:0 memory programming revision.
// - pin control bit 5: io pin push-pull 0, open-drain 1.
// - pin control bit 4: io pin input 0, output 1.
// - pin control bit 3: io pin level, low or released/high.
// - pin control bit 1: out pin push-pull 0, open-drain 1.
// - pin control bit 0: out pin level, low or released/high.
// - register defaults load from the memory when lockout releases.
// - memory addresses above 0FFFh read zero and ignore writes.
// - memory writes need the two-byte password back to back at 0Fh.
// - device may stretch scl low during a memory write.
`timescale 1ns/1ns
module pmu_i2c_register_slave #(
    parameter logic [7:0] PASSWORD_FIRST = 8'hA5, // arbitrary value
    parameter logic [7:0] PASSWORD_SECOND = 8'h5A, // arbitrary value
    parameter int MEM_DEPTH = 4096
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic undervoltage_lockout_i,
    input wire logic [3:0] otp_part_code_i,
    input wire logic [3:0] otp_die_revision_i,
    input wire logic [pmu_pkg::REV_FIELD_WIDTH-1:0] otp_program_revision_i,
    input wire logic [7:0] otp_pin_control_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_oe_n_o,
    output logic sda_oe_n_o,
    input wire logic io_pin_i,
    output logic io_pin_o,
    output logic io_pin_oe_n_o,
    output logic out_pin_o,
    output logic out_pin_oe_n_o,
    output logic second_regulator_enable_o,
    output logic sync_clock_enable_o,
    output logic memory_unlocked_o
);
    import pmu_pkg::*;

    if (MEM_DEPTH < 1 || MEM_DEPTH > 4096) begin : g_depth_check
        $error("MEM_DEPTH must be 1..4096");
    end

    logic [7:0] mem [0:MEM_DEPTH-1];
    i2c_state_t state_reg;
    logic scl_q_reg, sda_q_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic is_mem_reg, reading_reg;
    logic [1:0] byte_idx_reg;
    logic [15:0] addr_reg;
    logic [7:0] tx_reg;
    logic sda_low_reg, stretch_reg, stretch_pend_reg;
    logic [4:0] busy_cnt_reg;
    logic [7:0] pin_ctrl_reg;
    logic [3:0] part_code_field_reg, die_revision_field_reg;
    logic [REV_FIELD_WIDTH-1:0] prog_rev_reg;
    logic [1:0] pw_stage_reg;
    logic undervoltage_lockout_q_reg, guard_reg, sync_reg;

    // bus events
    wire scl_rise = scl_i && !scl_q_reg;
    wire scl_fall = !scl_i && scl_q_reg;
    wire start_det = scl_i && scl_q_reg && sda_q_reg && !sda_i;
    wire stop_det = scl_i && scl_q_reg && !sda_q_reg && sda_i;
    wire [7:0] shift_next = {shift_reg[6:0], sda_i};
    wire addr_hit_reg = shift_next[7:1] == REG_SLAVE_ADDR;
    wire addr_hit_mem = shift_next[7:1] == MEM_SLAVE_ADDR;
    wire undervoltage_lockout_release = undervoltage_lockout_q_reg && !undervoltage_lockout_i;
    wire mem_in_range = addr_reg <= MEM_TOP_ADDR && addr_reg < 16'(MEM_DEPTH);

    // read decode: unlisted offsets answer zero
    wire [7:0] reg_rdata =
        (addr_reg[7:0] == OFF_DEVICE_IDENTITY) ? {part_code_field_reg, die_revision_field_reg} :
        (addr_reg[7:0] == OFF_MEMORY_PROGRAM_REVISION) ? {1'b0, prog_rev_reg} :
        (addr_reg[7:0] == OFF_PIN_OUTPUT_CONTROL) ? pin_ctrl_reg :
        8'h00;
    wire [7:0] mem_rdata = mem_in_range ? mem[addr_reg[11:0]] : 8'h00;
    wire [7:0] rdata = is_mem_reg ? mem_rdata : reg_rdata;

    // write strobe: data byte completes on the eighth rising edge in ST_RX
    wire byte_done = scl_rise && bit_cnt_reg == 4'd7;
    wire rx_data = state_reg == ST_RX && byte_done;
    wire data_phase = is_mem_reg ? byte_idx_reg == 2'd2 : byte_idx_reg == 2'd1;
    wire wr_strobe = rx_data && data_phase;
    wire reg_wr = wr_strobe && !is_mem_reg;
    wire mem_wr = wr_strobe && is_mem_reg && mem_in_range && pw_stage_reg == 2'd2;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            undervoltage_lockout_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_i;
            sda_q_reg <= sda_i;
            undervoltage_lockout_q_reg <= undervoltage_lockout_i;
        end
    end

    // register bank: defaults loaded at lockout release
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pin_ctrl_reg <= PIN_CTRL_RESET;
            part_code_field_reg <= 4'h0;
            die_revision_field_reg <= 4'h0;
            prog_rev_reg <= '0;
        end else if (undervoltage_lockout_release) begin
            pin_ctrl_reg <= otp_pin_control_i & PIN_CTRL_WMASK;
            part_code_field_reg <= otp_part_code_i;
            die_revision_field_reg <= otp_die_revision_i;
            prog_rev_reg <= otp_program_revision_i;
        end else if (reg_wr && addr_reg[7:0] == OFF_PIN_OUTPUT_CONTROL) begin
            pin_ctrl_reg <= shift_next & PIN_CTRL_WMASK;
        end
    end

    // password sequencer: any mismatch at the password offset locks again
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || undervoltage_lockout_i) begin
            pw_stage_reg <= 2'd0;
        end else if (reg_wr && addr_reg[7:0] == OFF_PASSWORD) begin
            if (pw_stage_reg == 2'd0 && shift_next == PASSWORD_FIRST) begin
                pw_stage_reg <= 2'd1;
            end else if (pw_stage_reg == 2'd1 && shift_next == PASSWORD_SECOND) begin
                pw_stage_reg <= 2'd2;
            end else begin
                pw_stage_reg <= 2'd0;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (mem_wr) begin
            mem[addr_reg[11:0]] <= shift_next;
        end
    end

    // false-start guard: a start before the first stop after release is ignored
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            guard_reg <= 1'b1;
            sync_reg <= 1'b0;
        end else if (undervoltage_lockout_i) begin
            guard_reg <= 1'b1;
            sync_reg <= 1'b0;
        end else if (stop_det) begin
            guard_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else if (guard_reg && start_det) begin
            sync_reg <= 1'b1;
        end
    end

    // memory write stretch: armed by the write, applied from the next scl fall so the
    // high phase of the last data bit is never cut short by the slave
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || undervoltage_lockout_i) begin
            stretch_reg <= 1'b0;
            stretch_pend_reg <= 1'b0;
            busy_cnt_reg <= '0;
        end else if (mem_wr) begin
            stretch_pend_reg <= 1'b1;
            busy_cnt_reg <= 5'(MEM_BUSY_CYCLES);
        end else if (stretch_pend_reg && scl_fall) begin
            stretch_pend_reg <= 1'b0;
            stretch_reg <= 1'b1;
        end else if (stretch_reg && !scl_i) begin
            if (busy_cnt_reg == 5'd1) begin
                stretch_reg <= 1'b0;
            end
            busy_cnt_reg <= busy_cnt_reg - 5'd1;
        end
    end

    // serial state machine
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || undervoltage_lockout_i || stop_det) begin
            state_reg <= ST_IDLE;
            sda_low_reg <= 1'b0;
            bit_cnt_reg <= '0;
            byte_idx_reg <= '0;
            is_mem_reg <= 1'b0;
            reading_reg <= 1'b0;
            shift_reg <= '0;
            tx_reg <= '0;
            addr_reg <= '0;
        end else if (start_det) begin
            state_reg <= (guard_reg || sync_reg) ? ST_SKIP : ST_ADDR;
            sda_low_reg <= 1'b0;
            bit_cnt_reg <= '0;
            byte_idx_reg <= '0;
        end else begin
            if (scl_rise && bit_cnt_reg < 4'd8) begin
                shift_reg <= shift_next;
            end
            unique case (state_reg)
                ST_IDLE, ST_SKIP: begin
                    sda_low_reg <= 1'b0;
                end
                ST_ADDR: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'd1;
                    end
                    if (byte_done) begin
                        if (addr_hit_reg || addr_hit_mem) begin
                            is_mem_reg <= addr_hit_mem;
                            reading_reg <= sda_i;
                            tx_reg <= rdata;
                            state_reg <= ST_ACK;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_RX: begin
                    if (scl_rise) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'd1;
                    end
                    if (byte_done) begin
                        if (is_mem_reg && byte_idx_reg == 2'd0) begin
                            addr_reg[7:0] <= shift_next;
                        end else if (is_mem_reg && byte_idx_reg == 2'd1) begin
                            addr_reg[15:8] <= shift_next;
                        end else if (byte_idx_reg == 2'd0) begin
                            addr_reg <= {8'h00, shift_next};
                        end
                        if (!data_phase) begin
                            byte_idx_reg <= byte_idx_reg + 2'd1;
                        end
                        state_reg <= ST_ACK;
                    end
                end
                ST_ACK: begin
                    // drive ack from the falling edge after bit 8 through the ninth pulse
                    if (scl_fall && !sda_low_reg) begin
                        sda_low_reg <= 1'b1;
                    end else if (scl_fall && sda_low_reg) begin
                        sda_low_reg <= reading_reg && !tx_reg[7];
                        bit_cnt_reg <= '0;
                        state_reg <= reading_reg ? ST_TX : ST_RX;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'd1;
                        if (bit_cnt_reg == 4'd7) begin
                            sda_low_reg <= 1'b0;
                            state_reg <= ST_TXACK;
                        end else begin
                            sda_low_reg <= !tx_reg[3'd6 - bit_cnt_reg[2:0]];
                        end
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        if (sda_i) begin
                            state_reg <= ST_SKIP;
                        end else begin
                            addr_reg <= addr_reg + 16'd1;
                        end
                    end
                    if (scl_fall) begin
                        tx_reg <= rdata;
                        sda_low_reg <= !rdata[7];
                        bit_cnt_reg <= '0;
                        state_reg <= ST_TX;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign sda_oe_n_o = !sda_low_reg;
    assign scl_oe_n_o = !stretch_reg;
    assign sync_clock_enable_o = sync_reg;
    assign memory_unlocked_o = pw_stage_reg == 2'd2;

    // pin drivers: open-drain releases on a high level
    assign io_pin_o = pin_ctrl_reg[BIT_IO_LEVEL];
    assign io_pin_oe_n_o = !(pin_ctrl_reg[BIT_IO_DIR] &&
        (!pin_ctrl_reg[BIT_IO_TYPE] || !pin_ctrl_reg[BIT_IO_LEVEL]));
    assign second_regulator_enable_o = !pin_ctrl_reg[BIT_IO_DIR] && io_pin_i;
    assign out_pin_o = pin_ctrl_reg[BIT_OUT_LEVEL];
    assign out_pin_oe_n_o = pin_ctrl_reg[BIT_OUT_TYPE] && pin_ctrl_reg[BIT_OUT_LEVEL];
endmodule : pmu_i2c_register_slave

// >>> testbench/i2c_host_model.sv
// i2c host model: open-drain master, 1 = released
// assumes the testbench resolves each wire as a wired-and with pull-up
`timescale 1ns/1ns
module i2c_host_model (
    input wire logic clock_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask : tick
    // sda moves only with scl low; a stretched scl is waited out, bounded
    task automatic bit_io(input logic b, output logic r);
        int w;
        scl_o <= 1'b0;
        tick(2);
        sda_o <= b;
        tick(2);
        scl_o <= 1'b1;
        w = 0;
        @(posedge clock_i);
        while (scl_i !== 1'b1 && w < 100) begin
            @(posedge clock_i);
            w++;
        end
        tick(3);
        r = sda_i;
    endtask : bit_io
    // start and repeated start share one path: scl low, sda high, scl high, sda low
    task automatic start();
        scl_o <= 1'b0;
        tick(2);
        sda_o <= 1'b1;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b0;
        tick(4);
    endtask : start
    task automatic stop();
        scl_o <= 1'b0;
        tick(2);
        sda_o <= 1'b0;
        tick(2);
        scl_o <= 1'b1;
        tick(4);
        sda_o <= 1'b1;
        tick(4);
    endtask : stop
    task automatic wr(input logic [7:0] d, output logic nak);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, nak);
    endtask : wr
    task automatic rd(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
    endtask : rd
    // address byte then n bytes of b, high byte first; no stop
    task automatic wr_seq(input logic [6:0] sa, input logic [23:0] b, input int n,
        output logic nak);
        logic a;
        start();
        wr({sa, 1'b0}, nak);
        for (int i = n - 1; i >= 0; i--) begin
            wr(b[8*i +: 8], a);
            nak = nak | a;
        end
    endtask : wr_seq
    task automatic rd_at(input logic [6:0] sa, input logic [15:0] a, input int n,
        output logic [7:0] d, output logic nak);
        logic k;
        wr_seq(sa, {8'h00, a}, n, nak);
        start();
        wr({sa, 1'b1}, k);
        nak = nak | k;
        rd(1'b1, d);
    endtask : rd_at
endmodule : i2c_host_model

// >>> testbench/pmu_i2c_chk.sv
// checker for the pmu i2c register slave, bound to its ports
// assumes scl_i/sda_i are the resolved wire levels, synchronous to clock_i
`timescale 1ns/1ns
module pmu_i2c_chk (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic undervoltage_lockout_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_oe_n_o,
    input wire logic sda_oe_n_o,
    input wire logic io_pin_i,
    input wire logic io_pin_oe_n_o,
    input wire logic second_regulator_enable_o,
    input wire logic sync_clock_enable_o,
    input wire logic memory_unlocked_o
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence stop_seq;
        scl_i && $rose(sda_i);
    endsequence
    sequence stretch_seq;
        (!scl_oe_n_o) [*8];
    endsequence
    a_lockout_idle: assert property (undervoltage_lockout_i |-> ##[1:2] (sda_oe_n_o && scl_oe_n_o))
        else $error("bus not released during lockout");
    a_sda_low_phase: assert property (($changed(sda_oe_n_o) && !undervoltage_lockout_i
        && !$past(undervoltage_lockout_i)) |-> !$past(scl_i))
        else $error("sda driver changed while scl high");
    a_ack_hold: assert property (disable iff (!rst_n_i || undervoltage_lockout_i)
        ($rose(scl_i) && !sda_oe_n_o) |-> (!sda_oe_n_o) [*3])
        else $error("sda low not held through scl high");
    a_stretch_len: assert property (disable iff (!rst_n_i || undervoltage_lockout_i)
        $fell(scl_oe_n_o) |-> stretch_seq ##[6:12] scl_oe_n_o)
        else $error("scl stretch length wrong");
    a_stretch_low: assert property ($fell(scl_oe_n_o) |-> !$past(scl_i))
        else $error("stretch began while scl high");
    a_sync_off: assert property (stop_seq |-> ##[1:3] !sync_clock_enable_o)
        else $error("sync clock still on after stop");
    a_unlock_clear: assert property (undervoltage_lockout_i |-> ##[1:2] !memory_unlocked_o)
        else $error("unlock survived lockout");
    a_regen_off: assert property (!io_pin_oe_n_o |-> !second_regulator_enable_o)
        else $error("regulator enabled while io pin drives");
    a_regen_follow: assert property (second_regulator_enable_o |-> io_pin_i)
        else $error("regulator enable without io pin high");
endmodule : pmu_i2c_chk

bind pmu_i2c_register_slave pmu_i2c_chk u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .undervoltage_lockout_i(undervoltage_lockout_i),
    .scl_i(scl_i), .sda_i(sda_i), .scl_oe_n_o(scl_oe_n_o), .sda_oe_n_o(sda_oe_n_o),
    .io_pin_i(io_pin_i), .io_pin_oe_n_o(io_pin_oe_n_o),
    .second_regulator_enable_o(second_regulator_enable_o),
    .sync_clock_enable_o(sync_clock_enable_o), .memory_unlocked_o(memory_unlocked_o)
);

// >>> testbench/tb.sv
// self-checking bench for the pmu i2c register slave
// assumes the host model drives the bus and the bench resolves the wires
`timescale 1ns/1ns
module tb;
    import pmu_pkg::*;
    localparam logic [7:0] PW1 = 8'hA5;
    localparam logic [7:0] PW2 = 8'h5A;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic undervoltage_lockout = 1'b1;
    logic io_pin_i = 1'b1;
    logic [7:0] otp_pin = 8'h39;
    logic scl_h, sda_h, scl_oe_n, sda_oe_n, io_o, io_oe_n, out_o, out_oe_n, regen, sync_en, unl;
    wire logic scl_w = scl_h & scl_oe_n;
    wire logic sda_w = sda_h & sda_oe_n;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    always #2 clock_i = ~clock_i;
    pmu_i2c_register_slave #(.PASSWORD_FIRST(PW1), .PASSWORD_SECOND(PW2)) DUT (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .undervoltage_lockout_i(undervoltage_lockout),
        .otp_part_code_i(4'h9), .otp_die_revision_i(4'h6), .otp_program_revision_i(7'h2B),
        .otp_pin_control_i(otp_pin), .scl_i(scl_w), .sda_i(sda_w), .scl_oe_n_o(scl_oe_n),
        .sda_oe_n_o(sda_oe_n), .io_pin_i(io_pin_i), .io_pin_o(io_o), .io_pin_oe_n_o(io_oe_n),
        .out_pin_o(out_o), .out_pin_oe_n_o(out_oe_n), .second_regulator_enable_o(regen),
        .sync_clock_enable_o(sync_en), .memory_unlocked_o(unl));
    i2c_host_model host (.clock_i(clock_i), .scl_i(scl_w), .sda_i(sda_w),
        .scl_o(scl_h), .sda_o(sda_h));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic rreg(input logic [6:0] sa, input logic [15:0] a, input int n,
        input logic [7:0] exp);
        logic [7:0] d;
        logic nak;
        host.rd_at(sa, a, n, d, nak);
        check({7'h0, sda_oe_n}, 8'h01);
        host.stop();
        check({7'h0, nak}, 8'h00);
        check(d, exp);
    endtask : rreg
    task automatic wreg(input logic [6:0] sa, input logic [23:0] b, input int n);
        logic nak;
        host.wr_seq(sa, b, n, nak);
        host.stop();
        check({7'h0, nak}, 8'h00);
    endtask : wreg
    task automatic t_power();
        undervoltage_lockout <= 1'b0;
        host.tick(2);
        host.start();
        check({7'h0, sync_en}, 8'h01);
        host.stop();
        check({7'h0, sync_en}, 8'h00);
        rreg(REG_SLAVE_ADDR, OFF_DEVICE_IDENTITY, 1, 8'h96);
        rreg(REG_SLAVE_ADDR, OFF_MEMORY_PROGRAM_REVISION, 1, 8'h2B);
        rreg(REG_SLAVE_ADDR, OFF_PIN_OUTPUT_CONTROL, 1, 8'h39);
        $display("test power done");
    endtask : t_power
    task automatic t_pins();
        logic [7:0] tbl [9] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h38, 8'h01, 8'h03, 8'h02, 8'hFF};
        logic [7:0] m;
        logic io_drv, out_drv;
        foreach (tbl[i]) begin
            io_pin_i <= !io_pin_i;
            wreg(REG_SLAVE_ADDR, {8'h00, OFF_PIN_OUTPUT_CONTROL, tbl[i]}, 2);
            m = tbl[i] & PIN_CTRL_WMASK;
            io_drv = m[BIT_IO_DIR] & !(m[BIT_IO_LEVEL] & m[BIT_IO_TYPE]);
            out_drv = !(m[BIT_OUT_LEVEL] & m[BIT_OUT_TYPE]);
            check({6'h0, io_oe_n, regen}, {6'h0, !io_drv, !m[BIT_IO_DIR] & io_pin_i});
            if (io_drv) check({7'h0, io_o}, {7'h0, m[BIT_IO_LEVEL]});
            check({7'h0, out_oe_n}, {7'h0, !out_drv});
            if (out_drv) check({7'h0, out_o}, {7'h0, m[BIT_OUT_LEVEL]});
            rreg(REG_SLAVE_ADDR, OFF_PIN_OUTPUT_CONTROL, 1, m);
        end
        $display("test pins done");
    endtask : t_pins
    task automatic t_refuse();
        logic nak;
        rreg(REG_SLAVE_ADDR, 16'h0003, 1, 8'h00);
        rreg(REG_SLAVE_ADDR, OFF_PASSWORD, 1, 8'h00);
        host.wr_seq(7'h20, 24'h000002, 1, nak);
        host.stop();
        check({7'h0, nak}, 8'h01);
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_mem();
        wreg(REG_SLAVE_ADDR, {8'h00, OFF_PASSWORD, PW1}, 2);
        wreg(REG_SLAVE_ADDR, {8'h00, OFF_PASSWORD, PW2}, 2);
        check({7'h0, unl}, 8'h01);
        wreg(MEM_SLAVE_ADDR, 24'h1000C3, 3);
        rreg(MEM_SLAVE_ADDR, 16'h1000, 2, 8'hC3);
        wreg(MEM_SLAVE_ADDR, 24'h10107E, 3);
        rreg(MEM_SLAVE_ADDR, 16'h1010, 2, 8'h00);
        wreg(REG_SLAVE_ADDR, {8'h00, OFF_PASSWORD, 8'h00}, 2);
        check({7'h0, unl}, 8'h00);
        wreg(MEM_SLAVE_ADDR, 24'h100011, 3);
        rreg(MEM_SLAVE_ADDR, 16'h1000, 2, 8'hC3);
        $display("test memory done");
    endtask : t_mem
    task automatic t_lockout();
        logic nak;
        host.start();
        host.wr({REG_SLAVE_ADDR, 1'b0}, nak);
        undervoltage_lockout <= 1'b1;
        otp_pin <= 8'hD6;
        host.tick(3);
        check({6'h0, sda_oe_n, scl_oe_n}, 8'h03);
        undervoltage_lockout <= 1'b0;
        host.tick(2);
        // first transfer after release is dropped; after a stop the reloaded pin control default is read back
        host.wr_seq(REG_SLAVE_ADDR, 24'h000002, 1, nak);
        check({7'h0, nak}, 8'h01);
        check({7'h0, sync_en}, 8'h01);
        host.stop();
        check({7'h0, sync_en}, 8'h00);
        rreg(REG_SLAVE_ADDR, OFF_PIN_OUTPUT_CONTROL, 1, 8'h12);
        $display("test lockout done");
    endtask : t_lockout
    task automatic final_report();
        $display("tests %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    // about 10300 cycles are expected; the ceiling leaves room for stretches
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        t_power();
        t_pins();
        t_refuse();
        t_mem();
        t_lockout();
        final_report();
    end
endmodule : tb
